// ===== hw/te_act_map.vh
`ifndef TE_ACT_MAP_VH
`define TE_ACT_MAP_VH

// State codes, one per activation state
`define TE_F1 4'h1
`define TE_F2 4'h2
`define TE_F3 4'h3
`define TE_F4 4'h4
`define TE_F5 4'h5
`define TE_F6 4'h6
`define TE_F7 4'h7
`define TE_F8 4'h8
`define TE_STATE_RESET 4'h1

// Transmitted signal codes
`define TE_TX_INFO0 2'h0
`define TE_TX_INFO1 2'h1
`define TE_TX_INFO3 2'h3

// Error indication cause values
`define TE_CAUSE_ERROR    1'h0
`define TE_CAUSE_RECOVERY 1'h1

// Timing
`define TE_CLK_KHZ      40000
`define TE_T3_MS        1000
`define TE_DEBOUNCE_MS  750
`define TE_ID_WINDOW_US 5000

`endif

// ===== hw/te_sync3.v
`timescale 1ns/1ps
module te_sync3 (
    input  wire clk,    // System clock
    input  wire rst_n,  // Synchronised reset, active low
    input  wire din,    // Asynchronous level
    output reg  dout    // Filtered, synchronised level
);
    reg q1;
    reg q2;
    reg q3;

    // Three stages; a change counts only once stages two and three agree
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q1   <= 1'b0;
            q2   <= 1'b0;
            q3   <= 1'b0;
            dout <= 1'b0;
        end else begin
            q1 <= din;
            q2 <= q1;
            q3 <= q2;
            if (q2 == q3) begin
                dout <= q3;
            end
        end
    end
endmodule

// ===== hw/te_timer.v
`timescale 1ns/1ps
module te_timer #(
    parameter [31:0] LOAD = 32'h0000_0001
) (
    input  wire clk,      // System clock
    input  wire rst_n,    // Synchronised reset, active low
    input  wire start,    // Load and run, restarts a running timer
    input  wire stop,     // Abandon without expiry, wins over start
    output reg  running,  // Timer counting
    output reg  expired   // One-cycle pulse at expiry
);
    reg [31:0] count;

    // Down counter; a zero load would never expire, so treat it as one
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count   <= 32'h0000_0000;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (stop) begin
                running <= 1'b0;
            end else if (start) begin
                count   <= (LOAD == 32'h0000_0000) ? 32'h0000_0001 : LOAD;
                running <= 1'b1;
            end else if (running) begin
                if (count <= 32'h0000_0001) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end else begin
                    count <= count - 32'h0000_0001;
                end
            end
        end
    end
endmodule

// ===== hw/te_activation_fsm.v
// How it works
// R1: Power on in F1 enters F2
// R2: Power loss returns to F1 with indications
// R3: Line power detection events are ignored
// R4: Leaving F2 on INFO reports connected
// R5: Power loss from F3 up reports disconnected
// R6: INFO 0 in F6-F8 deactivates to F3
// R7: Unclassified signal in F4 enters F5
// R8: F5 reached within 5 ms of signal
// R9: Unsyncable zero patterns must still reach F5
// R10: Optional debounce timer after INFO 0 exit
// R11: Layer-2 deactivate withheld until debounce expiry
// R12: T3 expiry in F6 deactivates via F3
// R13: T3 covers the whole activation time
// R14: Error indication on framing loss, INFO 2
// R15: Recovery indication on INFO 2/4 in F8
// R16: Send INFO 1 in F4, INFO 3 F6/F7
// R17: Activate request starts T3; expiry deactivates
// R18: INFO 2 to F6, INFO 4 to F7
`timescale 1ns/1ps
`include "te_act_map.vh"
module te_activation_fsm #(
    parameter [31:0] T3_CYCLES       = `TE_T3_MS * `TE_CLK_KHZ,      // T3 length
    parameter [31:0] DEBOUNCE_CYCLES = `TE_DEBOUNCE_MS * `TE_CLK_KHZ // Debounce length
) (
    input  wire       CLK,           // 40 MHz clock
    input  wire       ARST_N,        // Asynchronous reset, active low
    input  wire       LOCAL_POWER,   // Local power good, asynchronous pin
    input  wire       RX_INFO0,      // Receiver sees INFO 0
    input  wire       RX_INFO2,      // Receiver classified INFO 2
    input  wire       RX_INFO4,      // Receiver classified INFO 4
    input  wire       RX_SIGNAL,     // Signal present, type not yet classified
    input  wire       RX_FRAME_LOST, // Receiver lost framing
    input  wire       ACT_REQ,       // Activate request from layer 2, pulse
    input  wire       DEBOUNCE_EN,   // Use deactivate debounce timer
    output reg  [1:0] TX_INFO,       // Signal to transmit
    output reg  [3:0] STATE,         // Current state code
    output reg        PH_AI,         // Activate indication to layer 2
    output wire       PH_DI,         // Deactivate indication to layer 2
    output reg        MPH_AI,        // Activate indication to management
    output reg        MPH_DI,        // Deactivate indication to management
    output reg        MPH_II_C,      // Connected indication
    output reg        MPH_II_D,      // Disconnected indication
    output reg        MPH_EI,        // Error indication
    output reg        MPH_EI_CAUSE   // Cause: 0 error, 1 recovery
);
    reg        rst_s1;
    reg        rst_n;
    wire       power_ok;
    reg  [3:0] next_state;
    reg  [1:0] next_tx;
    reg        next_ph_ai;
    reg        next_ph_di;
    reg        next_mph_ai;
    reg        next_mph_di;
    reg        next_ii_c;
    reg        next_ii_d;
    reg        next_ei;
    reg        next_cause;
    reg        ph_di_now;
    reg        t3_start;
    reg        t3_stop;
    reg        db_start;
    reg        db_cancel;
    wire       t3_expired;
    wire       db_running;
    wire       db_expired;
    reg        info0_exit;

    // Reset release through two flops
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // Power pin crosses in from outside the clock domain
    te_sync3 u_power_sync (
        .clk   (CLK),
        .rst_n (rst_n),
        .din   (LOCAL_POWER),
        .dout  (power_ok)
    );

    // Supervisory timer, long enough for the whole access to activate [R13]
    te_timer #(
        .LOAD (T3_CYCLES)
    ) u_t3 (
        .clk     (CLK),
        .rst_n   (rst_n),
        .start   (t3_start),
        .stop    (t3_stop),
        .running (),
        .expired (t3_expired)
    );

    // Debounce timer holding back the layer-2 deactivate [R10]
    te_timer #(
        .LOAD (DEBOUNCE_CYCLES)
    ) u_debounce (
        .clk     (CLK),
        .rst_n   (rst_n),
        .start   (db_start),
        .stop    (db_cancel),
        .running (db_running),
        .expired (db_expired)
    );

    // Transition matrix; there is no line-power input at all [R3]
    always @* begin
        next_state  = STATE;
        next_ph_ai  = 1'b0;
        ph_di_now   = 1'b0;
        next_mph_ai = 1'b0;
        next_mph_di = 1'b0;
        next_ii_c   = 1'b0;
        next_ii_d   = 1'b0;
        next_ei     = 1'b0;
        next_cause  = `TE_CAUSE_ERROR;
        t3_start    = 1'b0;
        t3_stop     = 1'b0;
        info0_exit  = 1'b0;
        if (STATE != `TE_F1 && !power_ok) begin
            // Power loss beats every line event
            next_state = `TE_F1; // [R2]
            t3_stop    = 1'b1;
            if (STATE >= `TE_F3) begin
                next_ii_d = 1'b1; // [R5]
            end
            if (STATE >= `TE_F4) begin
                next_mph_di = 1'b1; // [R2]
                ph_di_now   = 1'b1;
            end
        end else begin
            case (STATE)
                `TE_F1: begin
                    if (power_ok) begin
                        next_state = `TE_F2; // [R1]
                    end
                end
                `TE_F2: begin
                    if (RX_INFO4) begin
                        next_ii_c   = 1'b1; // [R4]
                        next_ph_ai  = 1'b1;
                        next_mph_ai = 1'b1;
                        next_state  = `TE_F7; // [R18]
                    end else if (RX_INFO2) begin
                        next_ii_c  = 1'b1; // [R4]
                        next_state = `TE_F6; // [R18]
                    end else if (RX_INFO0) begin
                        next_ii_c  = 1'b1; // [R4]
                        next_state = `TE_F3;
                    end
                end
                `TE_F3: begin
                    if (RX_INFO4) begin
                        next_ph_ai  = 1'b1;
                        next_mph_ai = 1'b1;
                        t3_stop     = 1'b1;
                        next_state  = `TE_F7; // [R18]
                    end else if (RX_INFO2) begin
                        // Also the way back after a brief T3 dip from F6 [R12]
                        next_state = `TE_F6; // [R18]
                    end else if (ACT_REQ) begin
                        t3_start   = 1'b1; // [R17]
                        next_state = `TE_F4;
                    end
                end
                `TE_F4, `TE_F5: begin
                    if (t3_expired) begin
                        next_mph_di = 1'b1; // [R17]
                        ph_di_now   = 1'b1;
                        next_state  = `TE_F3;
                    end else if (RX_INFO4) begin
                        next_ph_ai  = 1'b1;
                        next_mph_ai = 1'b1;
                        t3_stop     = 1'b1;
                        next_state  = `TE_F7; // [R18]
                    end else if (RX_INFO2) begin
                        next_state = `TE_F6; // [R18]
                    end else if (STATE == `TE_F4 && RX_SIGNAL) begin
                        // No waiting here, so the 5 ms bound holds unless power loss, T3 expiry, INFO 2 or INFO 4 wins first [R8]
                        next_state = `TE_F5; // [R7] [R9]
                    end
                end
                `TE_F6: begin
                    if (t3_expired) begin
                        next_mph_di = 1'b1; // [R12]
                        ph_di_now   = 1'b1;
                        next_state  = `TE_F3;
                    end else if (RX_INFO0) begin
                        next_mph_di = 1'b1; // [R6]
                        ph_di_now   = 1'b1;
                        next_state  = `TE_F3;
                    end else if (RX_INFO4) begin
                        next_ph_ai  = 1'b1;
                        next_mph_ai = 1'b1;
                        next_ei     = 1'b1; // [R15]
                        next_cause  = `TE_CAUSE_RECOVERY;
                        t3_stop     = 1'b1;
                        next_state  = `TE_F7; // [R18]
                    end else if (RX_FRAME_LOST) begin
                        next_ei    = 1'b1; // [R14]
                        next_cause = `TE_CAUSE_ERROR;
                        next_state = `TE_F8;
                    end
                end
                `TE_F7: begin
                    if (RX_INFO0) begin
                        next_mph_di = 1'b1; // [R6]
                        info0_exit  = 1'b1;
                        next_state  = `TE_F3;
                    end else if (RX_INFO2) begin
                        next_ei    = 1'b1; // [R14]
                        next_cause = `TE_CAUSE_ERROR;
                        next_state = `TE_F6;
                    end else if (RX_FRAME_LOST) begin
                        next_ei    = 1'b1; // [R14]
                        next_cause = `TE_CAUSE_ERROR;
                        next_state = `TE_F8;
                    end
                end
                `TE_F8: begin
                    if (t3_expired) begin
                        next_mph_di = 1'b1; // [R17]
                        ph_di_now   = 1'b1;
                        next_state  = `TE_F3;
                    end else if (RX_INFO0) begin
                        next_mph_di = 1'b1; // [R6]
                        next_ei     = 1'b1;
                        next_cause  = `TE_CAUSE_RECOVERY;
                        info0_exit  = 1'b1;
                        next_state  = `TE_F3;
                    end else if (RX_INFO4) begin
                        next_ph_ai  = 1'b1;
                        next_mph_ai = 1'b1;
                        next_ei     = 1'b1; // [R15]
                        next_cause  = `TE_CAUSE_RECOVERY;
                        t3_stop     = 1'b1;
                        next_state  = `TE_F7; // [R18]
                    end else if (RX_INFO2) begin
                        next_ei    = 1'b1; // [R15]
                        next_cause = `TE_CAUSE_RECOVERY;
                        next_state = `TE_F6; // [R18]
                    end
                end
                default: begin
                    next_state = `TE_F1;
                end
            endcase
        end
    end

    // Debounce control: withhold, cancel on F7 re-entry, else deliver later
    always @* begin
        db_start   = 1'b0;
        db_cancel  = 1'b0;
        next_ph_di = ph_di_now;
        if (info0_exit) begin
            if (DEBOUNCE_EN) begin
                db_start = 1'b1; // [R10]
            end else begin
                next_ph_di = 1'b1; // [R6]
            end
        end
        // Another deactivate already reaches layer 2, so a pending one is moot
        if (ph_di_now) begin
            db_cancel = 1'b1;
        end
        if (db_running && next_state == `TE_F7 && STATE != `TE_F7) begin
            db_cancel = 1'b1; // [R11]
        end
    end

    // Transmitted signal follows the next state
    always @* begin
        case (next_state)
            `TE_F4:  next_tx = `TE_TX_INFO1; // [R16]
            `TE_F6:  next_tx = `TE_TX_INFO3; // [R16]
            `TE_F7:  next_tx = `TE_TX_INFO3; // [R16]
            default: next_tx = `TE_TX_INFO0; // [R16]
        endcase
    end

    // State and indication registers
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            STATE        <= `TE_STATE_RESET;
            TX_INFO      <= `TE_TX_INFO0;
            PH_AI        <= 1'b0;
            MPH_AI       <= 1'b0;
            MPH_DI       <= 1'b0;
            MPH_II_C     <= 1'b0;
            MPH_II_D     <= 1'b0;
            MPH_EI       <= 1'b0;
            MPH_EI_CAUSE <= `TE_CAUSE_ERROR;
        end else begin
            STATE    <= next_state;
            TX_INFO  <= next_tx;
            PH_AI    <= next_ph_ai;
            MPH_AI   <= next_mph_ai;
            MPH_DI   <= next_mph_di;
            MPH_II_C <= next_ii_c;
            MPH_II_D <= next_ii_d;
            MPH_EI   <= next_ei;
            if (next_ei) begin
                MPH_EI_CAUSE <= next_cause;
            end
        end
    end

    // Layer-2 deactivate: immediate ones registered, debounced one from timer
    reg ph_di_reg;
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ph_di_reg <= 1'b0;
        end else begin
            ph_di_reg <= next_ph_di;
        end
    end

    assign PH_DI = ph_di_reg | db_expired; // [R11]
endmodule

// ===== verification/te_act_monitor.sv
`timescale 1ns/1ps
module te_act_monitor (
    input wire       CLK,           // Clock
    input wire       ARST_N,        // Reset
    input wire       LOCAL_POWER,   // Power pin
    input wire       RX_INFO0,      // INFO 0 seen
    input wire       RX_INFO2,      // INFO 2 seen
    input wire       RX_INFO4,      // INFO 4 seen
    input wire       RX_SIGNAL,     // Unclassified signal
    input wire       RX_FRAME_LOST, // Framing lost
    input wire       ACT_REQ,       // Activate request
    input wire [1:0] TX_INFO,       // Sent signal
    input wire [3:0] STATE,         // State code
    input wire       PH_AI,         // Activate, layer 2
    input wire       MPH_AI,        // Activate, management
    input wire       MPH_DI,        // Deactivate, management
    input wire       MPH_II_C,      // Connected
    input wire       MPH_II_D,      // Disconnected
    input wire       MPH_EI,        // Error
    input wire       MPH_EI_CAUSE   // Error cause
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    // Power steady long enough that the synchroniser agrees with the pin
    sequence s_pwr; LOCAL_POWER [*4]; endsequence
    sequence s_sig; STATE == 4'h4 && RX_SIGNAL && !RX_INFO2 && !RX_INFO4; endsequence

    property p_on; s_pwr ##0 STATE == 4'h1 |-> ##[1:6] STATE != 4'h1; endproperty
    property p_off; $fell(LOCAL_POWER) && STATE != 4'h1 |-> ##[1:6] STATE == 4'h1; endproperty
    property p_disc; $fell(LOCAL_POWER) && STATE >= 4'h3 |-> ##[1:6] MPH_II_D; endproperty
    property p_conn;
        s_pwr ##0 STATE == 4'h2 && (RX_INFO0 || RX_INFO2 || RX_INFO4)
            |=> MPH_II_C && STATE != 4'h2;
    endproperty
    property p_tx;
        TX_INFO == ((STATE == 4'h4) ? 2'h1 : (STATE == 4'h6 || STATE == 4'h7) ? 2'h3 : 2'h0);
    endproperty
    property p_act;
        s_pwr ##0 STATE == 4'h3 && ACT_REQ && !RX_INFO2 && !RX_INFO4 |=> STATE == 4'h4;
    endproperty
    property p_deact;
        s_pwr ##0 (STATE == 4'h6 || STATE == 4'h7) && RX_INFO0 |=> STATE == 4'h3 && MPH_DI;
    endproperty
    // T3 expiry outranks the signal in F4, so it may end the wait instead
    property p_sig; s_pwr ##0 s_sig |=> STATE == 4'h5 || MPH_DI; endproperty
    property p_act4;
        s_pwr ##0 STATE >= 4'h3 && STATE != 4'h7 && RX_INFO4 && !RX_INFO0
            |=> (STATE == 4'h7 && PH_AI && MPH_AI) || MPH_DI;
    endproperty
    property p_lost;
        s_pwr ##0 STATE == 4'h7 && RX_FRAME_LOST && !RX_INFO0 && !RX_INFO2
            |=> STATE == 4'h8 && MPH_EI && !MPH_EI_CAUSE;
    endproperty

    a_on: assert property (p_on) else $error("power on ignored");
    a_off: assert property (p_off) else $error("power loss ignored");
    a_disc: assert property (p_disc) else $error("no disconnected note");
    a_conn: assert property (p_conn) else $error("no connected note");
    a_tx: assert property (p_tx) else $error("wrong signal sent");
    a_act: assert property (p_act) else $error("request not taken");
    a_deact: assert property (p_deact) else $error("no deactivation");
    a_sig: assert property (p_sig) else $error("no identifying state");
    a_act4: assert property (p_act4) else $error("no activation");
    a_lost: assert property (p_lost) else $error("no lost framing");
endmodule

bind te_activation_fsm te_act_monitor u_mon (
    .CLK(CLK), .ARST_N(ARST_N), .LOCAL_POWER(LOCAL_POWER), .RX_INFO0(RX_INFO0),
    .RX_INFO2(RX_INFO2), .RX_INFO4(RX_INFO4), .RX_SIGNAL(RX_SIGNAL),
    .RX_FRAME_LOST(RX_FRAME_LOST), .ACT_REQ(ACT_REQ), .TX_INFO(TX_INFO), .STATE(STATE),
    .PH_AI(PH_AI), .MPH_AI(MPH_AI), .MPH_DI(MPH_DI), .MPH_II_C(MPH_II_C),
    .MPH_II_D(MPH_II_D), .MPH_EI(MPH_EI), .MPH_EI_CAUSE(MPH_EI_CAUSE));

// ===== verification/te_nt_model.sv
`timescale 1ns/1ps
module te_nt_model (
    input  wire       clk,          // Recovered clock
    input  wire [2:0] mode,         // Pattern the termination sends
    output reg        info0 = 1'b0, // INFO 0 seen
    output reg        info2 = 1'b0, // INFO 2 seen
    output reg        info4 = 1'b0, // INFO 4 seen
    output reg        sig   = 1'b0, // Signal not yet classified
    output reg        flost = 1'b0  // Framing lost
);
    // Classifier lags the line by a clock, as a real detector would
    always @(posedge clk) begin
        info0 <= (mode == 3'h1);
        info2 <= (mode == 3'h2);
        info4 <= (mode == 3'h3);
        sig   <= (mode == 3'h4); // Unsyncable zeros pattern
        flost <= (mode == 3'h5);
    end
endmodule

// ===== verification/test_te_activation_fsm.sv
`timescale 1ns/1ps
module test_te_activation_fsm;
    reg        CLK    = 1'b0;
    reg        ARST_N = 1'b0;
    reg        pwr    = 1'b0;
    reg        act    = 1'b0;
    reg        deb    = 1'b0;
    reg  [2:0] mode   = 3'h0;
    reg [31:0] rnd    = 32'hbb67f818;
    wire       i0, i2, i4, sig, fl, cause;
    wire [1:0] tx;
    wire [3:0] st;
    wire [6:0] puls;
    integer    err_total   = 0;
    integer    checks_done = 0;
    integer    cnt [0:6];
    integer    base [0:6];
    integer    i, k, n;

    always #12.5 CLK = ~CLK;

    te_nt_model nt (.clk(CLK), .mode(mode), .info0(i0), .info2(i2), .info4(i4),
        .sig(sig), .flost(fl));

    // Short timers keep the run brief
    te_activation_fsm #(.T3_CYCLES(32'd40), .DEBOUNCE_CYCLES(32'd30)) uut (
        .CLK(CLK), .ARST_N(ARST_N), .LOCAL_POWER(pwr), .RX_INFO0(i0), .RX_INFO2(i2),
        .RX_INFO4(i4), .RX_SIGNAL(sig), .RX_FRAME_LOST(fl), .ACT_REQ(act),
        .DEBOUNCE_EN(deb), .TX_INFO(tx), .STATE(st), .PH_AI(puls[0]), .PH_DI(puls[1]),
        .MPH_AI(puls[2]), .MPH_DI(puls[3]), .MPH_II_C(puls[4]), .MPH_II_D(puls[5]),
        .MPH_EI(puls[6]), .MPH_EI_CAUSE(cause));

    // Tally every one-cycle indication; outputs are unknown until reset reaches them
    always @(posedge CLK)
        for (k = 0; k < 7; k = k + 1)
            cnt[k] <= ARST_N ? cnt[k] + puls[k] : 0;

    function [31:0] xs(input [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction

    function [1:0] exp_tx(input [3:0] s);
        exp_tx = (s == 4'h4) ? 2'h1 : (s == 4'h6 || s == 4'h7) ? 2'h3 : 2'h0;
    endfunction

    task final_report;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task chk(input [7:0] s, input [7:0] e);
        checks_done = checks_done + 1;
        if (s !== e) begin
            err_total = err_total + 1;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task mark;
        for (i = 0; i < 7; i = i + 1)
            base[i] = cnt[i];
    endtask

    task dc(input integer idx, input integer e);
        chk(8'(cnt[idx] - base[idx]), 8'(e));
    endtask

    // Set the line pattern and wait, bounded, for the expected state
    task step(input [2:0] m, input [3:0] s);
        @(posedge CLK);
        mode <= m;
        #1;
        for (i = 0; i < 60 && st !== s; i = i + 1) begin
            @(posedge CLK);
            #1;
        end
        chk({4'h0, st}, {4'h0, s});
        chk({6'h0, tx}, {6'h0, exp_tx(s)});
        if (st !== s) final_report;
        repeat (2) @(posedge CLK);
        #1;
    endtask

    task pulse_act;
        @(posedge CLK);
        act <= 1'b1;
        @(posedge CLK);
        act <= 1'b0;
    endtask

    initial begin
        repeat (8) @(posedge CLK);
        ARST_N <= 1'b1;
        repeat (3) @(posedge CLK);
        pwr <= 1'b1;
        step(3'h0, 4'h2);
        mark;
        step(3'h1, 4'h3);
        dc(4, 1);
        pulse_act;
        step(3'h0, 4'h4);
        step(3'h4, 4'h5);
        step(3'h2, 4'h6);
        mark;
        step(3'h3, 4'h7);
        dc(0, 1);
        dc(2, 1);
        dc(6, 1);
        chk({7'h0, cause}, 8'h01);
        mark;
        step(3'h5, 4'h8);
        dc(6, 1);
        chk({7'h0, cause}, 8'h00);
        step(3'h2, 4'h6);
        chk({7'h0, cause}, 8'h01);
        mark;
        step(3'h1, 4'h3);
        dc(1, 1);
        // Quiet line lets T3 run out in F4
        pulse_act;
        step(3'h0, 4'h4);
        mark;
        step(3'h0, 4'h3);
        dc(1, 1);
        // T3 expiry in F6 with INFO 2 still present comes back to F6
        pulse_act;
        mark;
        step(3'h2, 4'h6);
        repeat (50) @(posedge CLK);
        #1;
        chk({4'h0, st}, 8'h06);
        dc(3, 1);
        @(posedge CLK);
        deb <= 1'b1;
        step(3'h3, 4'h7);
        mark;
        step(3'h1, 4'h3);
        dc(3, 1);
        dc(1, 0);
        repeat (40) @(posedge CLK);
        #1;
        dc(1, 1);
        step(3'h3, 4'h7);
        mark;
        step(3'h1, 4'h3);
        step(3'h3, 4'h7);
        repeat (40) @(posedge CLK);
        #1;
        dc(1, 0);
        // Random line patterns, requests and debounce choice
        for (n = 0; n < 400; n = n + 1) begin
            @(posedge CLK);
            rnd = xs(rnd);
            mode <= rnd[2:0];
            act <= rnd[3];
            deb <= rnd[4];
            #1;
            chk({6'h0, tx}, {6'h0, exp_tx(st)});
        end
        step(3'h3, 4'h7);
        mark;
        @(posedge CLK);
        pwr <= 1'b0;
        step(3'h3, 4'h1);
        dc(5, 1);
        dc(3, 1);
        dc(1, 1);
        // Mid-run reset, a silent power loss in F2, then INFO 4 straight from F2
        @(posedge CLK);
        ARST_N <= 1'b0;
        repeat (4) @(posedge CLK);
        ARST_N <= 1'b1;
        repeat (3) @(posedge CLK);
        pwr <= 1'b1;
        step(3'h0, 4'h2);
        mark;
        @(posedge CLK);
        pwr <= 1'b0;
        step(3'h0, 4'h1);
        dc(5, 0);
        dc(3, 0);
        @(posedge CLK);
        pwr <= 1'b1;
        step(3'h0, 4'h2);
        step(3'h3, 4'h7);
        dc(4, 1);
        dc(0, 1);
        dc(2, 1);
        final_report;
    end
endmodule
